// ===== core/dfs_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz mclk, AXI4-Lite register window of 40 bytes
// Notes:   Definitions only
`ifndef DFS_MAP_SVH
`define DFS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DFS_A_CTRL 8'h00
`define DFS_A_STOPSET 8'h04
`define DFS_A_TSEL0 8'h08
`define DFS_A_TSEL1 8'h0C
`define DFS_A_TSEL2 8'h10
`define DFS_A_SPDLIM 8'h14
`define DFS_A_ACCEL 8'h18
`define DFS_A_STATUS 8'h1C
`define DFS_A_ISTAT 8'h20
`define DFS_A_IMASK 8'h24

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define DFS_C_FAN 0
`define DFS_C_PLE 1
`define DFS_C_TRQ 2
`define DFS_C_TCLR 3
`define DFS_CTRL_RST 4'h2
`define DFS_STOP_RAMP 16'h270F
`define DFS_STOP_MAX 16'h03E8
`define DFS_TSEL_RST 16'h270F
`define DFS_RESP_OK 2'h0
`define DFS_RESP_ERR 2'h2

// ----------------------------------------------------------------
// Status function codes
// ----------------------------------------------------------------
`define DFS_FN_RUN 7'h00
`define DFS_FN_SU 7'h01
`define DFS_FN_FAN 7'h19
`define DFS_FN_LF 7'h62
`define DFS_FN_ABC 7'h63
`define DFS_FN_POS_MAX 16'h0063
`define DFS_FN_NEG_MIN 16'h0064
`define DFS_FN_NEG_MAX 16'h00C7
`define DFS_FN_NUM 100

// ----------------------------------------------------------------
// Timing: 100 ms stop-timer unit, 1 ms ramp step
// ----------------------------------------------------------------
`define DFS_CLK_NS 20
`define DFS_TICK_NS 100000000
`define DFS_RAMP_NS 1000000
`define DFS_TICK_CYC (`DFS_TICK_NS / `DFS_CLK_NS)
`define DFS_RAMP_CYC (`DFS_RAMP_NS / `DFS_CLK_NS)

`endif

// ===== core/dfs_pkg.sv
// Purpose: Types of the fan and stop supervisor
// Assumes: dfs_map.svh holds the numbers
// Notes:   One state struct each for the stop timer and the top
`include "dfs_map.svh"
package dfs_pkg;
  typedef enum logic [2:0] {ST_STOP, ST_RUN, ST_DECEL, ST_WAIT, ST_COAST} dfs_run_e;

  typedef struct packed {
    logic prev;
    logic active;
    logic [31:0] pre;
    logic [15:0] ticks;
    logic expired;
  } dfs_tmr_s;

  typedef struct packed {
    dfs_run_e st;
    logic start_prev;
    logic [15:0] ramp_cnt;
    logic [15:0] speed;
    logic en;
    logic trip;
    logic su;
    logic fan_cmd;
    logic fan_flt;
    logic [2:0] term;
    logic irq;
    logic [3:0] ctrl;
    logic [15:0] stopset;
    logic [2:0][15:0] tsel;
    logic [15:0] spdlim;
    logic [15:0] accel;
    logic [2:0] imask;
    logic [2:0] istat;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dfs_state_s;
endpackage

// ===== core/dfs_term_map.sv
// Purpose: Maps one output terminal to a status function with polarity
// Assumes: Function vector indexed by base code
// Notes:   Combinational; the top registers the result
`timescale 1ns/1ns
`include "dfs_map.svh"
module dfs_term_map
  import dfs_pkg::*;
(
  // Selection and status
  input wire logic [15:0] code,
  input wire logic [`DFS_FN_NUM-1:0] fn_vec,
  // Terminal level
  output logic level
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic term_level(input logic [15:0] c, input logic [`DFS_FN_NUM-1:0] v);
    logic [15:0] b;
    b = c - `DFS_FN_NEG_MIN;
    if (c <= `DFS_FN_POS_MAX)
      return v[c[6:0]];
    else if (c <= `DFS_FN_NEG_MAX)
      return !v[b[6:0]];
    else
      return 1'b0;
  endfunction

  // Terminal level from the selected function
  always_comb
  begin
    level = term_level(code, fn_vec);
  end
endmodule // dfs_term_map

// ===== core/dfs_stop_timer.sv
// Purpose: Timed output cut-off after the start command drops
// Assumes: limit in ticks of TICK_CYC clocks
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ns
`include "dfs_map.svh"
module dfs_stop_timer
  import dfs_pkg::*;
#(
  parameter int TICK_CYC = `DFS_TICK_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command and setting
  input wire logic start_cmd,
  input wire logic [15:0] limit,
  // Result
  output logic expired
);
  dfs_tmr_s s_q, s_d;

  if (TICK_CYC < 1)
    $error("TICK_CYC must be at least 1");

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.prev = start_cmd;
    s_d.expired = 1'b0;
    if (s_q.active)
    begin
      if (s_q.ticks >= limit)
      begin
        s_d.active = 1'b0;
        s_d.expired = 1'b1;
      end
      else if (s_q.pre == 32'(TICK_CYC - 1))
      begin
        s_d.pre = '0;
        s_d.ticks = s_q.ticks + 16'h0001;
      end
      else
        s_d.pre = s_q.pre + 32'h1;
    end
    // arm on fall, clear on return
    if (s_q.prev && !start_cmd)
    begin
      s_d.active = 1'b1;
      s_d.pre = '0;
      s_d.ticks = '0;
    end
    if (start_cmd)
      s_d.active = 1'b0;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign expired = s_q.expired;
endmodule // dfs_stop_timer

// ===== core/dfs_top.sv
// Purpose: Fan, stop method and status terminal supervisor of a drive
// Assumes: Synchronous inputs, AXI4-Lite register access
// Notes:   All outputs registered
//
// Function
// - Terminal code 0-99 drives active high, 100-199 drives active low.
// - One status function may be routed to several terminals together.
// - A terminal with a code outside the defined set stays inactive.
// - Fan mode zero keeps the fan on whenever powered.
// - Fan mode one runs fan while running, by temperature while stopped.
// - Fan mode zero flags a fault whenever the fan is stopped.
// - Fan mode one flags a fault if fan stops while commanded and running.
// - A fan fault drives display, fan fault and minor fault flags.
// - Stop setting at sentinel ramps the motor down when start drops.
// - Stop setting holding a time cuts output after that time elapses.
// - Running indication drops the moment the output stops.
// - Start during coasting restarts the output from zero speed.
// - In torque control the output speed is the speed limit.
// - Phase-loss protection, when enabled, stops output on an open phase.
// - With zero ramp time the up-to-speed flag does not toggle.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "dfs_map.svh"
module dfs_top
  import dfs_pkg::*;
#(
  parameter int TICK_CYC = `DFS_TICK_CYC,
  parameter int RAMP_CYC = `DFS_RAMP_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Commands and sensors
  input wire logic forward_start_cmd,
  input wire logic reverse_start_cmd,
  input wire logic [15:0] speed_ref,
  input wire logic fan_rotating,
  input wire logic temp_hot,
  input wire logic [2:0] phase_open,
  // Power stage
  output logic [15:0] out_speed,
  output logic output_enable,
  output logic running_ind,
  // Fan and status
  output logic fan_on_cmd,
  output logic fan_fault_display,
  output logic up_to_speed_flag,
  output logic minor_fault_flag,
  output logic alarm_relay_output,
  output logic phase_loss_trip,
  output logic [2:0] term_out,
  output logic irq
);
  dfs_state_s s_q, s_d;
  logic start;
  logic ramp_en;
  logic instant;
  logic timed;
  logic do_wr;
  logic expired;
  logic stop_ev;
  logic [2:0] w1c;
  logic [15:0] tgt;
  logic [2:0] term_lv;
  logic [`DFS_FN_NUM-1:0] fn_vec;

  if (RAMP_CYC < 1 || RAMP_CYC > 65536)
    $error("RAMP_CYC out of range");

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ramp_step(input logic [15:0] cur, input logic [15:0] t,
                                            input logic tick, input logic inst);
    if (inst)
      return t;
    else if (!tick || cur == t)
      return cur;
    else if (cur < t)
      return cur + 16'h0001;
    else
      return cur - 16'h0001;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `DFS_A_IMASK;
  endfunction

  // ----------------------------------------------------------------
  // Stop timer and terminal mapping
  // ----------------------------------------------------------------
  dfs_stop_timer #(.TICK_CYC(TICK_CYC)) u_tmr (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start_cmd(start),
    .limit(s_q.stopset),
    .expired(expired)
  );

  // Status functions available to the terminals
  always_comb
  begin
    fn_vec = '0;
    fn_vec[`DFS_FN_RUN] = s_q.en;
    fn_vec[`DFS_FN_SU] = s_q.su;
    fn_vec[`DFS_FN_FAN] = s_q.fan_flt;
    fn_vec[`DFS_FN_LF] = s_q.fan_flt;
    fn_vec[`DFS_FN_ABC] = s_q.trip;
  end

  for (genvar g = 0; g < 3; g++)
  begin : g_term
    dfs_term_map u_map (
      .code(s_q.tsel[g]),
      .fn_vec(fn_vec),
      .level(term_lv[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    start = forward_start_cmd | reverse_start_cmd;
    s_d.start_prev = start;
    ramp_en = s_q.ramp_cnt == 16'(RAMP_CYC - 1);
    s_d.ramp_cnt = ramp_en ? 16'h0000 : s_q.ramp_cnt + 16'h0001;
    instant = s_q.accel == 16'h0000;
    timed = s_q.stopset <= `DFS_STOP_MAX;
    stop_ev = 1'b0;
    tgt = s_q.ctrl[`DFS_C_TRQ] ? s_q.spdlim : speed_ref;
    case (s_q.st)
      ST_STOP, ST_COAST:
      begin
        s_d.speed = '0;
        if (start && !s_q.trip)
        begin
          s_d.st = ST_RUN;
          s_d.en = 1'b1;
        end
      end
      ST_RUN:
      begin
        s_d.speed = ramp_step(s_q.speed, tgt, ramp_en, instant);
        if (!start)
          s_d.st = timed ? ST_WAIT : ST_DECEL;
      end
      ST_DECEL:
      begin
        if (start)
          s_d.st = ST_RUN;
        else if (s_q.speed == 16'h0000)
        begin
          s_d.st = ST_STOP;
          s_d.en = 1'b0;
          stop_ev = 1'b1;
        end
        else
          s_d.speed = ramp_step(s_q.speed, 16'h0000, ramp_en, instant);
      end
      ST_WAIT:
      begin
        if (start)
          s_d.st = ST_RUN;
        else if (expired)
        begin
          s_d.st = ST_COAST;
          s_d.en = 1'b0;
          s_d.speed = '0;
          stop_ev = 1'b1;
        end
      end
      default:
      begin
        s_d.st = ST_STOP;
        s_d.en = 1'b0;
      end
    endcase

    // Trip clear strobe, then the trip itself so a new fault wins
    if (s_q.ctrl[`DFS_C_TCLR])
      s_d.trip = 1'b0;
    s_d.ctrl[`DFS_C_TCLR] = 1'b0;
    if (s_q.ctrl[`DFS_C_PLE] && |phase_open && s_q.en)
    begin
      s_d.trip = 1'b1;
      s_d.en = 1'b0;
      s_d.speed = '0;
      s_d.st = ST_COAST;
    end

    // no compare when ramp time is zero
    s_d.su = instant ? s_d.en : (s_d.en && s_d.speed == tgt);

    // mode one by run or temperature
    s_d.fan_cmd = !s_q.ctrl[`DFS_C_FAN] | s_q.en | temp_hot;
    s_d.fan_flt = !s_q.ctrl[`DFS_C_FAN] ? !fan_rotating : (s_q.en & s_q.fan_cmd & !fan_rotating);
    s_d.term = term_lv;

    // Write address and data, taken in either order
    if (s_axi_awvalid && s_q.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready)
    begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    w1c = '0;
    if (do_wr)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.awaddr) ? `DFS_RESP_OK : `DFS_RESP_ERR;
      case (s_q.awaddr)
        `DFS_A_CTRL: s_d.ctrl = 4'(wmerge(32'(s_q.ctrl), s_q.wdata, s_q.wstrb));
        `DFS_A_STOPSET: s_d.stopset = 16'(wmerge(32'(s_q.stopset), s_q.wdata, s_q.wstrb));
        `DFS_A_TSEL0: s_d.tsel[0] = 16'(wmerge(32'(s_q.tsel[0]), s_q.wdata, s_q.wstrb));
        `DFS_A_TSEL1: s_d.tsel[1] = 16'(wmerge(32'(s_q.tsel[1]), s_q.wdata, s_q.wstrb));
        `DFS_A_TSEL2: s_d.tsel[2] = 16'(wmerge(32'(s_q.tsel[2]), s_q.wdata, s_q.wstrb));
        `DFS_A_SPDLIM: s_d.spdlim = 16'(wmerge(32'(s_q.spdlim), s_q.wdata, s_q.wstrb));
        `DFS_A_ACCEL: s_d.accel = 16'(wmerge(32'(s_q.accel), s_q.wdata, s_q.wstrb));
        `DFS_A_ISTAT: w1c = s_q.wdata[2:0] & {3{s_q.wstrb[0]}};
        `DFS_A_IMASK: s_d.imask = 3'(wmerge(32'(s_q.imask), s_q.wdata, s_q.wstrb));
        default: w1c = '0;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && s_q.arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = is_mapped(s_axi_araddr) ? `DFS_RESP_OK : `DFS_RESP_ERR;
      case (s_axi_araddr)
        `DFS_A_CTRL: s_d.rdata = 32'(s_q.ctrl);
        `DFS_A_STOPSET: s_d.rdata = 32'(s_q.stopset);
        `DFS_A_TSEL0: s_d.rdata = 32'(s_q.tsel[0]);
        `DFS_A_TSEL1: s_d.rdata = 32'(s_q.tsel[1]);
        `DFS_A_TSEL2: s_d.rdata = 32'(s_q.tsel[2]);
        `DFS_A_SPDLIM: s_d.rdata = 32'(s_q.spdlim);
        `DFS_A_ACCEL: s_d.rdata = 32'(s_q.accel);
        `DFS_A_STATUS: s_d.rdata = {24'h0, s_q.st, s_q.trip, s_q.su, s_q.fan_flt, s_q.fan_cmd, s_q.en};
        `DFS_A_ISTAT: s_d.rdata = 32'(s_q.istat);
        `DFS_A_IMASK: s_d.rdata = 32'(s_q.imask);
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // Sticky events: fan fault, trip, stop; a new event beats the clear
    s_d.istat = (s_q.istat & ~w1c) | {stop_ev, s_d.trip & ~s_q.trip, s_d.fan_flt & ~s_q.fan_flt};
    s_d.irq = |(s_d.istat & s_d.imask);
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.ctrl <= `DFS_CTRL_RST;
      s_q.stopset <= `DFS_STOP_RAMP;
      s_q.tsel <= {3{`DFS_TSEL_RST}};
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign out_speed = s_q.speed;
  assign output_enable = s_q.en;
  assign running_ind = s_q.en;
  assign fan_on_cmd = s_q.fan_cmd;
  assign fan_fault_display = s_q.fan_flt;
  assign minor_fault_flag = s_q.fan_flt;
  assign up_to_speed_flag = s_q.su;
  assign alarm_relay_output = s_q.trip;
  assign phase_loss_trip = s_q.trip;
  assign term_out = s_q.term;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_trip;
    s_q.ctrl[`DFS_C_PLE] && |phase_open && output_enable |=> !output_enable && phase_loss_trip;
  endproperty
  a_trip: assert property (p_trip) else $error("open phase did not trip");

  property p_no_trip;
    !s_q.ctrl[`DFS_C_PLE] && !phase_loss_trip |=> !phase_loss_trip;
  endproperty
  a_no_trip: assert property (p_no_trip) else $error("trip while disabled");

  property p_fan0;
    !sys_rst && !s_q.ctrl[`DFS_C_FAN] |=> fan_on_cmd;
  endproperty
  a_fan0: assert property (p_fan0) else $error("fan off in mode zero");

  property p_fan1;
    s_q.ctrl[`DFS_C_FAN] && output_enable |=> fan_on_cmd;
  endproperty
  a_fan1: assert property (p_fan1) else $error("fan off while running");

  property p_flt0;
    !sys_rst && !s_q.ctrl[`DFS_C_FAN] && !fan_rotating |=> fan_fault_display && minor_fault_flag;
  endproperty
  a_flt0: assert property (p_flt0) else $error("missed fan fault mode zero");

  property p_flt1;
    s_q.ctrl[`DFS_C_FAN] && output_enable && fan_on_cmd && !fan_rotating |=> fan_fault_display;
  endproperty
  a_flt1: assert property (p_flt1) else $error("missed fan fault mode one");

  property p_restart;
    s_q.st == ST_COAST && (forward_start_cmd || reverse_start_cmd) && !phase_loss_trip
      |=> output_enable && out_speed == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("coast restart not from zero");

  property p_cut;
    s_q.st == ST_WAIT && expired && !forward_start_cmd && !reverse_start_cmd
      |=> !output_enable && !running_ind && out_speed == 16'h0000;
  endproperty
  a_cut: assert property (p_cut) else $error("timed cut missed");

  property p_su_hold;
    // Flag was computed with the ramp time of the cycle before
    output_enable && $past(s_q.accel) == 16'h0000 |-> up_to_speed_flag;
  endproperty
  a_su_hold: assert property (p_su_hold) else $error("up-to-speed toggled");

  property p_torque;
    s_q.ctrl[`DFS_C_TRQ] && s_q.accel == 16'h0000 && s_q.st == ST_RUN && !phase_open[0]
      && !phase_open[1] && !phase_open[2] |=> out_speed == $past(s_q.spdlim);
  endproperty
  a_torque: assert property (p_torque) else $error("torque speed not limit");

  c_restart: cover property (s_q.st == ST_COAST ##1 s_q.st == ST_RUN);
  c_cut: cover property (s_q.st == ST_WAIT ##1 s_q.st == ST_COAST);
  c_trip: cover property ($rose(phase_loss_trip));
  c_fan: cover property ($rose(fan_fault_display) && s_q.ctrl[`DFS_C_FAN]);
endmodule // dfs_top

// ===== tb/dfs_plant.sv
// Purpose: Cooling fan and output phase model
// Assumes: Fan follows its command one edge later
// Notes:   Faults only on bench command
`timescale 1ns/1ns
module dfs_plant
(
  // Clock
  input wire logic mclk,
  // Device side
  input wire logic fan_on_cmd,
  input wire logic output_enable,
  output logic fan_rotating,
  output logic [2:0] phase_open,
  // Fault injection
  input wire logic fan_stuck,
  input wire logic [2:0] phase_cut
);
  // Fan spins up or stops one edge after its command
  always @(posedge mclk)
  begin
    fan_rotating <= fan_on_cmd & !fan_stuck;
  end
  // An open phase only shows while current flows
  assign phase_open = output_enable ? phase_cut : 3'h0;
endmodule // dfs_plant

// ===== tb/tb_drive_fan_stop_supervisor.sv
// Purpose: Self-checking bench of the fan and stop supervisor
// Assumes: Short stop tick and ramp step
// Notes:   Random values from a fixed seed
`timescale 1ns/1ns
`include "dfs_map.svh"
module tb_drive_fan_stop_supervisor;
  logic mclk = 0;
  logic sys_rst = 1;
  logic [7:0] s_axi_awaddr = 0;
  logic [7:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic forward_start_cmd = 0, reverse_start_cmd = 0, temp_hot = 0, fan_stuck = 0;
  logic [15:0] speed_ref = 0;
  logic [2:0] phase_cut = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fan_rotating;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic [2:0] phase_open, term_out;
  logic [15:0] out_speed, sl;
  logic output_enable, running_ind, fan_on_cmd, fan_fault_display, up_to_speed_flag;
  logic minor_fault_flag, alarm_relay_output, phase_loss_trip, irq;
  int failures = 0, checked = 0, cycles = 0, n, tc;

  // Design and far-side model
  dfs_top #(.TICK_CYC(4), .RAMP_CYC(2)) uut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .forward_start_cmd, .reverse_start_cmd, .speed_ref, .fan_rotating, .temp_hot, .phase_open, .out_speed,
    .output_enable, .running_ind, .fan_on_cmd, .fan_fault_display, .up_to_speed_flag, .minor_fault_flag,
    .alarm_relay_output, .phase_loss_trip, .term_out, .irq);
  dfs_plant pm (.mclk, .fan_on_cmd, .output_enable, .fan_rotating, .phase_open, .fan_stuck, .phase_cut);

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Cycle ceiling cuts a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      give_verdict;
    end
  end

  // Expected terminal level for a code and a status
  function logic term_exp(input int code, input logic st);
    if (code < 100)
      return st;
    return (code < 200) ? !st : 1'b0;
  endfunction

  // Edges from start drop to output cut for a stop time
  function int stop_edges(input int s);
    return s * 4 + 4;
  endfunction

  task give_verdict;
  begin
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
  begin
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask

  task step(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Waits a bounded time for the output to reach a level
  task till_oe(input logic v);
  begin
    n = 0;
    while (output_enable !== v && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
  end
  endtask

  // Register write, address and data offered together
  task axw(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  end
  endtask

  // Register read
  task axr(input logic [7:0] a);
  begin
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  end
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h82c4d821));
    step(10);
    sys_rst <= 1'b0;
    axr(`DFS_A_CTRL);
    chk(rd, 32'h2);
    axr(`DFS_A_STOPSET);
    chk(rd, 32'h270F);
    axr(8'h30);
    chk(rd, 32'h0);
    chk(rr, `DFS_RESP_ERR);
    axw(8'h31, 32'h1);
    chk(rr, `DFS_RESP_ERR);
    tc = $urandom_range(999, 200);
    axw(`DFS_A_TSEL0, 0);
    axw(`DFS_A_TSEL1, 100);
    axw(`DFS_A_TSEL2, tc);
    chk(rr, `DFS_RESP_OK);
    step(3);
    chk(term_out, {term_exp(tc, 0), term_exp(100, 0), term_exp(0, 0)});
    chk(fan_on_cmd, 1'b1);
    forward_start_cmd <= 1'b1;
    speed_ref <= 16'($urandom);
    step(6);
    chk(term_out, {term_exp(tc, 1), term_exp(100, 1), term_exp(0, 1)});
    chk({running_ind, fan_on_cmd}, 2'b11);
    axw(`DFS_A_STOPSET, 2);
    forward_start_cmd <= 1'b0;
    step(6);
    forward_start_cmd <= 1'b1;
    step(20);
    chk(output_enable, 1'b1);
    forward_start_cmd <= 1'b0;
    till_oe(0);
    chk(n >= stop_edges(2) - 2 && n <= stop_edges(2) + 2, 1'b1);
    chk(running_ind, 1'b0);
    reverse_start_cmd <= 1'b1;
    till_oe(1);
    chk(out_speed, 16'h0000);
    speed_ref <= 16'h0014;
    axw(`DFS_A_ACCEL, 1);
    axw(`DFS_A_STOPSET, 16'h270F);
    step(10);
    reverse_start_cmd <= 1'b0;
    step(6);
    chk(output_enable, 1'b1);
    till_oe(0);
    chk({n < 60, out_speed}, {1'b1, 16'h0000});
    sl = 16'($urandom_range(65535, 1));
    axw(`DFS_A_ACCEL, 0);
    axw(`DFS_A_SPDLIM, sl);
    axw(`DFS_A_CTRL, 6);
    forward_start_cmd <= 1'b1;
    step(10);
    chk(out_speed, sl);
    axw(`DFS_A_CTRL, 2);
    repeat (30)
    begin
      @(posedge mclk);
      speed_ref <= 16'($urandom);
      chk(up_to_speed_flag, 1'b1);
    end
    phase_cut <= 3'(1 << $urandom_range(2, 0));
    step(4);
    chk({phase_loss_trip, alarm_relay_output, output_enable}, 3'b110);
    axr(`DFS_A_ISTAT);
    chk({rd[1], irq}, 2'b10);
    axw(`DFS_A_IMASK, 2);
    step(2);
    chk(irq, 1'b1);
    axw(`DFS_A_ISTAT, 2);
    step(2);
    chk(irq, 1'b0);
    axw(`DFS_A_CTRL, 8);
    step(10);
    chk({phase_loss_trip, output_enable}, 2'b01);
    phase_cut <= 3'h0;
    forward_start_cmd <= 1'b0;
    till_oe(0);
    axw(`DFS_A_TSEL2, 25);
    fan_stuck <= 1'b1;
    step(4);
    chk({fan_fault_display, minor_fault_flag, term_out[2]}, 3'b111);
    axw(`DFS_A_CTRL, 1);
    repeat (6)
    begin
      temp_hot <= 1'($urandom_range(1, 0));
      step(3);
      chk({fan_on_cmd, fan_fault_display}, {temp_hot, 1'b0});
    end
    forward_start_cmd <= 1'b1;
    temp_hot <= 1'b0;
    step(5);
    chk({fan_on_cmd, fan_fault_display, minor_fault_flag}, 3'b111);
    fan_stuck <= 1'b0;
    step(4);
    chk(fan_fault_display, 1'b0);
    give_verdict;
  end
endmodule // tb_drive_fan_stop_supervisor
